// [logic/cmpcall_defines.svh]
// constants for the compare and relative call unit
`ifndef CMPCALL_DEFINES_SVH
`define CMPCALL_DEFINES_SVH
`define OPC_HI          31
`define OPC_LO          26
`define OPC_REG_BIT     31
`define OPC_CALL_REL    6'h3E
`define SEL_EQ          5'h19
`define SEL_GT          5'h1A
`define SEL_GE          5'h1B
`define SEL_GEU         5'h1C
`define SEL_GTU         5'h1D
`define SEL_NE          5'h1F
`define RA_INDEX        5'h1D
`define PC_STEP         32'h00000004
`define CALL_ISSUE_CYC  3'h4
`define CMP_RESULT_CYC  2'h2
`endif

// [logic/cmpcall_pkg.sv]
// types shared by the compare and relative call unit
package cmpcall_pkg;
   typedef enum logic [5:0] {
      OP_EQ  = 6'h01,
      OP_NE  = 6'h02,
      OP_GT  = 6'h04,
      OP_GE  = 6'h08,
      OP_GTU = 6'h10,
      OP_GEU = 6'h20
   } cmp_op_type;

   // one register file write
   typedef struct packed {
      logic        en;
      logic [4:0]  idx;
      logic [31:0] data;
   } rf_write_type;

   // one program counter redirect
   typedef struct packed {
      logic        en;
      logic [31:0] target;
   } pc_redirect_type;

   // decoded instruction fields
   typedef struct packed {
      logic        is_call;
      logic        is_cmp;
      logic        reg_form;
      cmp_op_type  op;
      logic [4:0]  src_a;
      logic [4:0]  src_b;
      logic [4:0]  dest;
      logic [15:0] short_imm;
      logic [25:0] long_imm;
   } decode_type;
endpackage : cmpcall_pkg

// [logic/cmpcall_decoder.sv]
// field decoder for compare and relative call instructions
`timescale 1ns/1ns
`include "cmpcall_defines.svh"
module cmpcall_decoder (
   // instruction word
   input  wire logic [31:0]        instr,
   // decoded fields
   output cmpcall_pkg::decode_type dec
);
   import cmpcall_pkg::*;

   logic [5:0] opc;
   logic [4:0] sel;
   logic       sel_ok;
   cmp_op_type op;

   assign opc = instr[`OPC_HI:`OPC_LO];
   assign sel = opc[4:0];

   // low five bits pick the compare kind
   always_comb begin
      sel_ok = 1'b1;
      op     = OP_EQ;
      case (sel) // see RQ1
         `SEL_EQ:  op = OP_EQ;
         `SEL_NE:  op = OP_NE;
         `SEL_GT:  op = OP_GT;
         `SEL_GE:  op = OP_GE;
         `SEL_GTU: op = OP_GTU;
         `SEL_GEU: op = OP_GEU;
         default:  sel_ok = 1'b0;
      endcase
   end

   // field extraction; register forms carry a third index
   always_comb begin
      dec.is_call   = (opc == `OPC_CALL_REL); // see RQ2
      dec.long_imm  = instr[25:0]; // see RQ2
      dec.is_cmp    = sel_ok && (opc != `OPC_CALL_REL)
                      && (!instr[`OPC_REG_BIT] || instr[10:0] == 11'h000); // see RQ3
      dec.reg_form  = instr[`OPC_REG_BIT]; // see RQ1
      dec.op        = op;
      dec.src_a     = instr[25:21]; // see RQ3
      dec.src_b     = instr[20:16];
      dec.dest      = instr[`OPC_REG_BIT] ? instr[15:11] : instr[20:16]; // see RQ4
      dec.short_imm = instr[15:0]; // see RQ4
   end
endmodule : cmpcall_decoder

// [logic/cmpcall_compare.sv]
// 32-bit comparator producing a single outcome bit
`timescale 1ns/1ns
module cmpcall_compare #(
   parameter int WIDTH = 32
) (
   // operands and kind
   input  wire logic [WIDTH-1:0]     opa,
   input  wire logic [WIDTH-1:0]     opb,
   input  cmpcall_pkg::cmp_op_type   op,
   // outcome
   output logic                      hit
);
   import cmpcall_pkg::*;

   logic eq;
   logic gts;
   logic gtu;

   assign eq  = (opa == opb);
   assign gts = ($signed(opa) > $signed(opb)); // see RQ13
   assign gtu = (opa > opb);

   // one comparator serves all six kinds
   always_comb begin
      case (op)
         OP_EQ:   hit = eq; // see RQ9
         OP_NE:   hit = !eq; // see RQ10
         OP_GT:   hit = gts; // see RQ11
         OP_GE:   hit = gts | eq; // see RQ12
         OP_GTU:  hit = gtu; // see RQ15
         OP_GEU:  hit = gtu | eq; // see RQ14
         default: hit = 1'b0;
      endcase
   end
endmodule : cmpcall_compare

// [logic/compare_and_relative_call_unit.sv]
// execution unit for compares and the relative call
// Notes on behaviour
// RQ1: opcode is bits 31:26; bit 31 set means register compare; low five select.
// RQ2: opcode 111110 is relative call, long immediate in bits 25:0.
// RQ3: register compares: sources 25:21 and 20:16, destination 15:11, 10:0 zero.
// RQ4: immediate compares: source 25:21, destination 20:16, short immediate 15:0.
// RQ5: relative call writes call address plus 4 into return address register.
// RQ6: new pc is pc plus sign-extended long immediate shifted left two.
// RQ7: call return value ready after 1 cycle; call occupies 4 issue cycles.
// RQ8: compare issues in 1 cycle; result usable after 2 cycles.
// RQ9: equal compare writes 1 when operands equal, else 0.
// RQ10: not-equal compare writes 1 when operands differ, else 0.
// RQ11: greater compare writes 1 when first exceeds second, else 0.
// RQ12: greater-or-equal writes 1 when first not less than second, else 0.
// RQ13: signed greater and greater-or-equal treat operands as two's complement.
// RQ14: unsigned greater-or-equal treats both operands as unsigned.
// RQ15: unsigned greater writes 1 when first strictly larger unsigned, else 0.
// RQ16: equal, not-equal and signed immediate forms sign-extend the short immediate.
// RQ17: unsigned immediate forms zero-extend the short immediate.
// RQ18: compare result is 32 bits, upper 31 zero, outcome in bit 0.
// RQ19: pc used for call return and target is the call's own address.
`timescale 1ns/1ns
`include "cmpcall_defines.svh"
module compare_and_relative_call_unit (
   // clock and reset
   input  wire logic                     ref_clk,
   input  wire logic                     nrst,
   // issue from the decoder
   input  wire logic                     issue_valid,
   input  wire logic [31:0]              instr,
   input  wire logic [31:0]              instr_pc,
   // operands read from the register file
   input  wire logic [31:0]              src_a_data,
   input  wire logic [31:0]              src_b_data,
   // register read indices
   output logic [4:0]                    rd_a_idx_r,
   output logic [4:0]                    rd_b_idx_r,
   // results
   output cmpcall_pkg::rf_write_type     rf_wr_r,
   output cmpcall_pkg::pc_redirect_type  pc_redir_r,
   output logic                          issue_ready_r,
   output logic                          illegal_r
);
   import cmpcall_pkg::*;

   typedef enum logic [2:0] {
      ST_IDLE = 3'b001,
      ST_CMP  = 3'b010,
      ST_CALL = 3'b100
   } state_type;

   decode_type      dec;
   logic            hit;
   logic [31:0]     opb;
   logic [31:0]     ext_imm;

   state_type       state_r;
   state_type       state_nxt;
   logic [2:0]      busy_cnt_r;
   logic [2:0]      busy_cnt_nxt;
   cmp_op_type      op_r;
   cmp_op_type      op_nxt;
   logic            reg_form_r;
   logic            reg_form_nxt;
   logic [4:0]      dest_r;
   logic [4:0]      dest_nxt;
   logic [15:0]     imm_r;
   logic [15:0]     imm_nxt;
   logic [4:0]      rd_a_nxt;
   logic [4:0]      rd_b_nxt;
   rf_write_type    rf_wr_nxt;
   pc_redirect_type pc_redir_nxt;
   logic            ready_nxt;
   logic            illegal_nxt;

   cmpcall_decoder u_dec (
      .instr (instr),
      .dec   (dec)
   );

   // signed kinds sign-extend, unsigned kinds zero-extend
   always_comb begin
      if (op_r == OP_GTU || op_r == OP_GEU) begin
         ext_imm = {16'h0000, imm_r}; // see RQ17
      end else begin
         ext_imm = {{16{imm_r[15]}}, imm_r}; // see RQ16
      end
   end

   assign opb = reg_form_r ? src_b_data : ext_imm;

   cmpcall_compare #(
      .WIDTH (32)
   ) u_cmp (
      .opa (src_a_data),
      .opb (opb),
      .op  (op_r),
      .hit (hit)
   );

   // sequencer: compare takes an operand cycle then writes, call holds issue
   always_comb begin
      state_nxt    = state_r;
      busy_cnt_nxt = busy_cnt_r;
      op_nxt       = op_r;
      reg_form_nxt = reg_form_r;
      dest_nxt     = dest_r;
      imm_nxt      = imm_r;
      rd_a_nxt     = rd_a_idx_r;
      rd_b_nxt     = rd_b_idx_r;
      rf_wr_nxt    = '0;
      pc_redir_nxt = '0;
      ready_nxt    = issue_ready_r;
      illegal_nxt  = 1'b0;
      case (state_r)
         ST_IDLE: begin
            if (issue_valid && issue_ready_r) begin
               if (dec.is_call) begin
                  // return value written one cycle after issue
                  rf_wr_nxt.en   = 1'b1; // see RQ7
                  rf_wr_nxt.idx  = `RA_INDEX;
                  rf_wr_nxt.data = instr_pc + `PC_STEP; // see RQ5, see RQ19
                  pc_redir_nxt.en     = 1'b1;
                  pc_redir_nxt.target = instr_pc
                     + {{4{dec.long_imm[25]}}, dec.long_imm, 2'b00}; // see RQ6
                  busy_cnt_nxt = `CALL_ISSUE_CYC - 3'h1; // see RQ7
                  ready_nxt    = 1'b0;
                  state_nxt    = ST_CALL;
               end else if (dec.is_cmp) begin
                  op_nxt       = dec.op;
                  reg_form_nxt = dec.reg_form;
                  dest_nxt     = dec.dest;
                  imm_nxt      = dec.short_imm;
                  rd_a_nxt     = dec.src_a;
                  rd_b_nxt     = dec.src_b;
                  // issue stays open: compares issue every cycle
                  state_nxt    = ST_CMP; // see RQ8
               end else begin
                  illegal_nxt = 1'b1;
               end
            end
         end
         ST_CMP: begin
            // operands arrive; result written in second cycle after issue
            rf_wr_nxt.en   = 1'b1; // see RQ8
            rf_wr_nxt.idx  = dest_r;
            rf_wr_nxt.data = {31'h0, hit}; // see RQ18
            state_nxt      = ST_IDLE;
            if (issue_valid && dec.is_cmp) begin
               op_nxt       = dec.op;
               reg_form_nxt = dec.reg_form;
               dest_nxt     = dec.dest;
               imm_nxt      = dec.short_imm;
               rd_a_nxt     = dec.src_a;
               rd_b_nxt     = dec.src_b;
               state_nxt    = ST_CMP;
            end else if (issue_valid && !dec.is_call) begin
               illegal_nxt = 1'b1;
            end
            // a call right behind a compare is dropped with no stall: the write
            // port is busy with the compare, so the issuer must send it again
         end
         ST_CALL: begin
            if (busy_cnt_r == 3'h1) begin
               ready_nxt = 1'b1;
               state_nxt = ST_IDLE;
            end
            busy_cnt_nxt = busy_cnt_r - 3'h1;
         end
         default: begin
            state_nxt = ST_IDLE;
            ready_nxt = 1'b1;
         end
      endcase
   end

   // state registers, synchronous reset
   always_ff @(posedge ref_clk) begin
      if (!nrst) begin
         state_r       <= ST_IDLE;
         busy_cnt_r    <= 3'h0;
         op_r          <= OP_EQ;
         reg_form_r    <= 1'b0;
         dest_r        <= 5'h00;
         imm_r         <= 16'h0000;
         rd_a_idx_r    <= 5'h00;
         rd_b_idx_r    <= 5'h00;
         rf_wr_r       <= '0;
         pc_redir_r    <= '0;
         issue_ready_r <= 1'b1;
         illegal_r     <= 1'b0;
      end else begin
         state_r       <= state_nxt;
         busy_cnt_r    <= busy_cnt_nxt;
         op_r          <= op_nxt;
         reg_form_r    <= reg_form_nxt;
         dest_r        <= dest_nxt;
         imm_r         <= imm_nxt;
         rd_a_idx_r    <= rd_a_nxt;
         rd_b_idx_r    <= rd_b_nxt;
         rf_wr_r       <= rf_wr_nxt;
         pc_redir_r    <= pc_redir_nxt;
         issue_ready_r <= ready_nxt;
         illegal_r     <= illegal_nxt;
      end
   end
endmodule : compare_and_relative_call_unit

// [bench/cmpcall_asserts.sv]
// port checker for the compare and relative call unit
`timescale 1ns/1ns
`include "cmpcall_defines.svh"
module cmpcall_asserts (
   // clock and reset
   input wire logic                         ref_clk,
   input wire logic                         nrst,
   // issue side
   input wire logic                         issue_valid,
   input wire logic [31:0]                  instr,
   input wire logic [31:0]                  instr_pc,
   // results
   input wire logic [4:0]                   rd_a_idx_r,
   input wire logic [4:0]                   rd_b_idx_r,
   input wire cmpcall_pkg::rf_write_type    rf_wr_r,
   input wire cmpcall_pkg::pc_redirect_type pc_redir_r,
   input wire logic                         issue_ready_r,
   input wire logic                         illegal_r
);
   import cmpcall_pkg::*;
   logic        take, call_go, cmp_go, ill_go, prev_cmp;
   logic [4:0]  dest;
   logic [31:0] tgt;
   // decode what the unit must accept this cycle
   assign take = issue_valid && issue_ready_r;
   assign call_go = take && instr[31:26] == `OPC_CALL_REL && !prev_cmp;
   assign cmp_go = take && (!instr[31] || instr[10:0] == 11'h0) && instr[30:26] inside
                   {`SEL_EQ, `SEL_GT, `SEL_GE, `SEL_GEU, `SEL_GTU, `SEL_NE};
   assign ill_go = take && !cmp_go && instr[31:26] != `OPC_CALL_REL;
   assign dest = instr[31] ? instr[15:11] : instr[20:16];
   assign tgt = instr_pc + {{4{instr[25]}}, instr[25:0], 2'b00};
   // a call right behind a compare is dropped, so it must not count as a call
   always_ff @(posedge ref_clk) prev_cmp <= nrst && cmp_go;
   default clocking cb @(posedge ref_clk); endclocking
   default disable iff (!nrst);
   sequence s_shadow; !issue_ready_r [*3] ##1 issue_ready_r; endsequence
   sequence s_cmp_done;
      ##2 rf_wr_r.en && rf_wr_r.idx == $past(dest, 2) && rf_wr_r.data[31:1] == 31'h0;
   endsequence
   property p_call_ra; call_go |=> rf_wr_r.en && rf_wr_r.idx == `RA_INDEX
      && rf_wr_r.data == $past(instr_pc) + `PC_STEP; endproperty
   property p_call_tgt; call_go |=> pc_redir_r.en && pc_redir_r.target == $past(tgt); endproperty
   property p_redir_src; pc_redir_r.en |-> $past(call_go); endproperty
   property p_call_busy; call_go |=> s_shadow; endproperty
   property p_cmp_idx; cmp_go |=> rd_a_idx_r == $past(instr[25:21])
      && rd_b_idx_r == $past(instr[20:16]); endproperty
   property p_cmp_wr; cmp_go |-> s_cmp_done; endproperty
   property p_cmp_issue; cmp_go |=> issue_ready_r; endproperty
   property p_wr_src; rf_wr_r.en |-> $past(call_go) || $past(cmp_go, 2); endproperty
   property p_ill; $past(nrst) |-> illegal_r == $past(ill_go); endproperty
   a_call_ra: assert property (p_call_ra) else $error("bad return write");
   a_call_tgt: assert property (p_call_tgt) else $error("bad call target");
   a_redir_src: assert property (p_redir_src) else $error("stray redirect");
   a_call_busy: assert property (p_call_busy) else $error("bad call shadow");
   a_cmp_idx: assert property (p_cmp_idx) else $error("bad read index");
   a_cmp_wr: assert property (p_cmp_wr) else $error("bad compare write");
   a_cmp_issue: assert property (p_cmp_issue) else $error("compare stalls");
   a_wr_src: assert property (p_wr_src) else $error("stray write");
   a_ill: assert property (p_ill) else $error("bad illegal flag");
endmodule : cmpcall_asserts

// [bench/tb.sv]
// self-checking bench for the compare and relative call unit
`timescale 1ns/1ns
`include "cmpcall_defines.svh"
module tb;
   import cmpcall_pkg::*;
   logic            ref_clk = 0, nrst = 0, issue_valid = 0, issue_ready_r, illegal_r;
   logic [31:0]     instr = 32'h0, instr_pc = 32'h0, src_a_data, src_b_data, w, b;
   logic [4:0]      rd_a_idx_r, rd_b_idx_r;
   rf_write_type    rf_wr_r;
   pc_redirect_type pc_redir_r;
   logic [31:0]     rf [32];
   logic [31:0]     seed = 32'h0000003D;
   logic [37:0]     ew [int];
   logic [32:0]     ep [int];
   logic            ei [int];
   int              cyc = 0, n_mismatch = 0, checked = 0;
   logic            cmp_prev = 1'b0, cmp_now;
   logic [4:0]      sels [6] = '{`SEL_EQ, `SEL_GT, `SEL_GE, `SEL_GEU, `SEL_GTU, `SEL_NE};
   compare_and_relative_call_unit uut (.ref_clk, .nrst, .issue_valid, .instr, .instr_pc,
      .src_a_data, .src_b_data, .rd_a_idx_r, .rd_b_idx_r, .rf_wr_r, .pc_redir_r,
      .issue_ready_r, .illegal_r);
   // register file stand-in, answers combinationally
   assign src_a_data = rf[rd_a_idx_r];
   assign src_b_data = rf[rd_b_idx_r];
   initial begin
      forever #50 ref_clk = ~ref_clk;
   end
   function automatic logic [31:0] lfsr(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction : lfsr
   function automatic logic hit(input logic [4:0] s, input logic [31:0] a, input logic [31:0] c);
      case (s)
         `SEL_EQ: return a == c;
         `SEL_NE: return a != c;
         `SEL_GT: return $signed(a) > $signed(c);
         `SEL_GE: return $signed(a) >= $signed(c);
         `SEL_GTU: return a > c;
         default: return a >= c;
      endcase
   endfunction : hit
   // reference model: book what each accepted word must produce and when
   // keys are the edge whose registered outputs the next falling edge sees
   always @(posedge ref_clk) begin
      cyc++;
      cmp_now = 1'b0;
      if (nrst && issue_valid && issue_ready_r) begin
         if (instr[31:26] == `OPC_CALL_REL) begin
            // a call right behind a compare is dropped: the write port is busy
            if (!cmp_prev) begin
               ew[cyc] = {1'b1, `RA_INDEX, instr_pc + `PC_STEP};
               ep[cyc] = {1'b1, instr_pc + {{4{instr[25]}}, instr[25:0], 2'b00}};
            end
         end else if (instr[30:26] inside {sels} && (!instr[31] || instr[10:0] == 11'h0)) begin
            b = instr[30:27] == 4'hE ? {16'h0, instr[15:0]} : {{16{instr[15]}}, instr[15:0]};
            if (instr[31]) b = rf[instr[20:16]];
            ew[cyc+1] = {1'b1, instr[31] ? instr[15:11] : instr[20:16], 31'h0,
                         hit(instr[30:26], rf[instr[25:21]], b)};
            cmp_now = 1'b1;
         end else ei[cyc] = 1;
      end
      cmp_prev = cmp_now;
   end
   task automatic report(input bit bad, input string m);
      checked++;
      if (bad) begin
         n_mismatch++;
         $display("Error at %0t ns: %s", $time, m);
      end
   endtask : report
   task automatic chk_wr(input logic [37:0] e);
      report(rf_wr_r.en !== e[37] || (e[37] && rf_wr_r !== e), "register write");
   endtask : chk_wr
   task automatic chk_pc(input logic [32:0] e);
      report(pc_redir_r.en !== e[32] || (e[32] && pc_redir_r !== e), "redirect");
   endtask : chk_pc
   task automatic chk_ill(input logic e);
      report(illegal_r !== e, "illegal flag");
   endtask : chk_ill
   // outputs are settled by the falling edge
   always @(negedge ref_clk) if (nrst) begin
      chk_wr(ew.exists(cyc) ? ew[cyc] : 38'h0);
      chk_pc(ep.exists(cyc) ? ep[cyc] : 33'h0);
      chk_ill(ei.exists(cyc));
   end
   task automatic drive(input logic [31:0] x, input logic [31:0] p);
      @(negedge ref_clk);
      issue_valid = 1;
      instr = x;
      instr_pc = p;
   endtask : drive
   task automatic idle(input int n);
      @(negedge ref_clk);
      issue_valid = 0;
      repeat (n) @(negedge ref_clk);
   endtask : idle
   // boundary operands in the low registers make equal and sign cases likely
   task automatic fill;
      for (int i = 0; i < 32; i++) begin
         seed = lfsr(seed);
         rf[i] = seed;
      end
      rf[0:5] = '{32'h0, 32'hFFFFFFFF, 32'h80000000, 32'h7FFFFFFF, 32'hFFFF8000, 32'h00008000};
   endtask : fill
   task automatic summarize;
      $display("checked %0d mismatches %0d", checked, n_mismatch);
      if (n_mismatch == 0 && checked > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : summarize
   initial begin
      fill;
      repeat (5) @(negedge ref_clk);
      nrst = 1;
      // all compare kinds in both forms, back to back
      for (int r = 0; r < 2; r++) begin
         for (int i = 0; i < 48; i++) begin
            seed = lfsr(seed);
            w = {1'b0, sels[i%6], 2'b00, seed[2:0], seed[10:6], seed[11] ? 16'h8000 : seed[31:16]};
            if ((i / 6) % 2) w = {1'b1, sels[i%6], 2'b00, seed[2:0], 2'b00, seed[5:3], seed[10:6],
                                  11'h0};
            drive(w, seed);
         end
         idle(4);
         fill;
      end
      $display("test compares done");
      // calls with a compare held up through the shadow, extreme offsets first
      for (int i = 0; i < 6; i++) begin
         seed = lfsr(seed);
         w = {`OPC_CALL_REL, i == 0 ? 26'h2000000 : i == 1 ? 26'h1FFFFFF : seed[31:6]};
         // later calls come right behind a compare: dropped once, then issued again
         if (i > 2) begin
            drive({1'b1, `SEL_NE, 15'h0443, 11'h0}, seed);
            drive(w, seed);
         end
         drive(w, {seed[29:0], 2'b00});
         repeat (5) drive({1'b1, `SEL_NE, 15'h0443, 11'h0}, seed);
         idle(2);
      end
      $display("test calls done");
      // words that are neither compare nor call, mixed with a good one
      drive(32'h00000000, seed);
      drive({1'b1, `SEL_EQ, 15'h0, 11'h001}, seed);
      drive(32'h78000000, seed);
      drive({1'b0, `SEL_GTU, 10'h0, 16'hFFFF}, seed);
      idle(4);
      $display("test illegal done");
      summarize;
   end
   // the run needs well under a thousand cycles
   initial begin
      #500000;
      n_mismatch++;
      summarize;
   end
endmodule : tb
bind compare_and_relative_call_unit cmpcall_asserts chk (.ref_clk, .nrst, .issue_valid, .instr,
   .instr_pc, .rd_a_idx_r, .rd_b_idx_r, .rf_wr_r, .pc_redir_r, .issue_ready_r, .illegal_r);
